// File: design/weld_cfg.svh
// Constants of the weld-cycle supervisor: register offsets, field
// positions, reset values and timing counts. Definitions only.
`ifndef WELD_CFG_SVH
`define WELD_CFG_SVH
// Register byte offsets (one aligned 32-bit word each)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WELD_TIME   8'h08
`define REG_PEAK_TGT    8'h0c
`define REG_ENERGY_TGT  8'h10
`define REG_TIME_HI     8'h14
`define REG_TIME_LO     8'h18
`define REG_PEAK_HI     8'h1c
`define REG_PEAK_LO     8'h20
`define REG_ENERGY_HI   8'h24
`define REG_ENERGY_LO   8'h28
`define REG_FSTART      8'h2c
`define REG_SPAN        8'h30
`define REG_AMPL        8'h34
`define REG_ADDR        8'h38
`define REG_MEAS_TIME   8'h3c
`define REG_MEAS_PEAK   8'h40
`define REG_MEAS_ENERGY 8'h44
`define REG_OP_POWER    8'h48
`define REG_SCAN_FREQ   8'h4c
// Control register bit positions
`define CTRL_RUN        0
`define CTRL_HOST       1
`define CTRL_SCAN       2
`define CTRL_MEMWR      3
// Status register bit positions
`define ST_RUN          0
`define ST_SCAN         1
`define ST_HOST         2
`define ST_ERR_TIME_HI  3
`define ST_ERR_TIME_LO  4
`define ST_ERR_PEAK_HI  5
`define ST_ERR_PEAK_LO  6
`define ST_ERR_EN_HI    7
`define ST_ERR_EN_LO    8
// Reset values and the amplitude limit
`define SPAN_MAX_HZ     16'd1000
`define ADDR_DEFAULT    8'h06
`define AMPL_MAX        10'd1000
`define FSTART_DEFAULT  17'd21000
// Weld time tick: 10 ms units at 200 MHz
`define CLK_HZ          200000000
`define TICK_MS         10
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)
`define SCAN_STEP_HZ    16'd1
`endif

// File: design/weld_pkg.sv
// Types used by the weld-cycle supervisor; its helpers use none of them.
// Assumes weld_cfg.svh is compiled alongside for the constants.
package weld_pkg;
   // Weld sequencer states, Gray coded along idle-run-check
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_CHECK = 2'b11
   } weld_state_t;
   // Measured values of one weld
   typedef struct packed {
      logic [31:0] time_ticks;
      logic [31:0] peak_w;
      logic [31:0] energy_ws;
   } meas_t;
   // Bound violation flags
   typedef struct packed {
      logic time_hi;
      logic time_lo;
      logic peak_hi;
      logic peak_lo;
      logic en_hi;
      logic en_lo;
   } err_t;
endpackage

// File: design/weld_bound_chk.sv
// Checks one measured value against upper and lower bounds.
// Assumes value and bounds are stable while eval is high.
`timescale 1ns/1ps
`default_nettype none
module weld_bound_chk (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clr,
   input  wire logic        eval,
   input  wire logic [31:0] value,
   input  wire logic [31:0] hi,
   input  wire logic [31:0] lo,
   output logic             err_hi,
   output logic             err_lo
);
   // All state of the checker
   typedef struct packed {
      logic hi_f;
      logic lo_f;
   } chk_t;
   chk_t s_q, s_d;

   // A zero bound is disabled; evaluation wins over a same-cycle clear
   always_comb begin
      s_d = s_q;
      if (clr) begin
         s_d = '0;
      end
      if (eval) begin
         s_d.hi_f = (hi != 32'h0) && (value > hi);
         s_d.lo_f = (lo != 32'h0) && (value < lo);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign err_hi = s_q.hi_f;
   assign err_lo = s_q.lo_f;
endmodule
`default_nettype wire

// File: design/weld_scan.sv
// Downward frequency scan from start frequency to start minus span.
// Assumes start and span are held by the caller; span already limited.
`timescale 1ns/1ps
`include "weld_cfg.svh"
`default_nettype none
module weld_scan (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        go,
   input  wire logic        step,
   input  wire logic [16:0] fstart,
   input  wire logic [15:0] span,
   output logic [16:0]      freq,
   output logic             busy
);
   // All state of the scanner
   typedef struct packed {
      logic [16:0] f;
      logic        on;
   } scan_t;
   scan_t s_q, s_d;
   logic [16:0] f_end;

   // Floor of the scan, never below zero
   always_comb begin
      f_end = (fstart > {1'b0, span}) ? fstart - {1'b0, span} : 17'h0;
   end

   // Start at fstart, step down one hertz per step, stop at floor
   always_comb begin
      s_d = s_q;
      if (go) begin
         s_d.f  = fstart;
         s_d.on = 1'b1;
      end else if (s_q.on && step) begin
         if (s_q.f <= f_end + 17'(`SCAN_STEP_HZ)) begin
            s_d.f  = f_end;
            s_d.on = 1'b0;
         end else begin
            s_d.f = s_q.f - 17'(`SCAN_STEP_HZ);
         end
      end else if (!s_q.on) begin
         s_d.f = fstart;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '{f: `FSTART_DEFAULT, on: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign freq = s_q.f;
   assign busy = s_q.on;
endmodule
`default_nettype wire

// File: design/weld_limit_supervisor.sv
// Weld-cycle supervisor: ends welds on time, peak power or energy, checks
// bounds, holds frequency, span, amplitude and address settings.
// Assumes one clock MCLK, power samples valid with MEAS_VALID.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "weld_cfg.svh"
`default_nettype none
module weld_limit_supervisor (
   input  wire logic        MCLK,
   input  wire logic        RESET_N,
   // Avalon-MM slave
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Front panel and measurement
   input  wire logic        HOST_ATTACHED,
   input  wire logic        PANEL_BUTTON,
   input  wire logic        PANEL_ENC_CW,
   input  wire logic        PANEL_MEMWR_SEL,
   input  wire logic [31:0] MEAS_POWER,
   input  wire logic        MEAS_VALID,
   // Outputs
   output logic             US_OUT_EN,
   output logic [9:0]       AMPL_SET,
   output logic [9:0]       AMPL_BAR,
   output logic [16:0]      FREQ_OUT,
   output logic             NVM_COMMIT,
   output logic             MENU_TO_FSTART,
   output logic             WELD_ERROR,
   output logic [7:0]       NET_ADDR
);
   // All state of the supervisor except the bound checker flags and the scan engine state
   typedef struct packed {
      weld_pkg::weld_state_t st;
      logic [31:0] t_dur;       // Weld duration, 10 ms units
      logic [31:0] pk_tgt;      // Peak target, W
      logic [31:0] en_tgt;      // Energy target, Ws
      logic [31:0] t_hi;
      logic [31:0] t_lo;
      logic [31:0] pk_hi;
      logic [31:0] pk_lo;
      logic [31:0] en_hi;
      logic [31:0] en_lo;
      logic [16:0] fstart;
      logic [15:0] span;
      logic [9:0]  ampl;
      logic [7:0]  addr;
      logic        host_run;    // Run request from host
      logic        panel_run;   // Run request from panel
      logic        scan_go;     // Scan start pulse
      logic        memwr;       // Commit pulse
      logic        btn_prev;
      logic        enc_prev;
      logic [31:0] tick_cnt;    // Cycles into current 10 ms tick
      logic [31:0] energy_acc;  // Watt-cycles not yet making up a whole Ws
      logic [31:0] op_power;
      weld_pkg::meas_t meas;
      logic [31:0] rdata;
      logic        wait_q;
      logic        out_en;
      logic        menu_fs;
      logic [9:0]  bar;
   } sup_t;
   sup_t s_q, s_d;

   // Helper signals
   logic         run_req;      // Arbitrated run request
   logic         stop_hit;     // Any termination target reached
   logic         eval;         // End-of-weld bound evaluation
   logic         clr;          // Start-of-weld clear
   logic         acc;          // Bus access accepted this cycle
   logic         tick;         // One 10 ms tick elapsed
   logic [31:0]  wmask;        // Byte-lane mask for writes
   logic [31:0]  wv;           // Merged write value
   logic [31:0]  rd;           // Read mux
   weld_pkg::err_t err;
   logic [16:0]  scan_freq;
   logic         scan_busy;

   // Byte enables into a bit mask, one lane per generate step
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{AVS_BYTEENABLE[gi]}};
      end
   endgenerate

   // Host overrides panel while attached; panel resumes at once after
   assign run_req = HOST_ATTACHED ? s_q.host_run : s_q.panel_run;
   assign tick    = (s_q.tick_cnt == 32'(`TICK_CYCLES - 1));
   // Writes land at the edge where the master sees waitrequest low
   assign acc     = (AVS_READ || AVS_WRITE) && !s_q.wait_q;

   // Termination targets; a zero target is ignored
   always_comb begin
      stop_hit = 1'b0;
      if ((s_q.t_dur != 32'h0) &&
          (s_q.meas.time_ticks >= s_q.t_dur)) begin
         stop_hit = 1'b1;
      end
      if ((s_q.pk_tgt != 32'h0) &&
          (s_q.meas.peak_w >= s_q.pk_tgt)) begin
         stop_hit = 1'b1;
      end
      if ((s_q.en_tgt != 32'h0) &&
          (s_q.meas.energy_ws >= s_q.en_tgt)) begin
         stop_hit = 1'b1;
      end
   end

   assign clr  = (s_q.st == weld_pkg::ST_IDLE) && run_req;
   assign eval = (s_q.st == weld_pkg::ST_CHECK);

   // Bound checks, one per measured quantity
   weld_bound_chk u_chk_time (
      .clk    (MCLK),
      .rst_n  (RESET_N),
      .clr    (clr),
      .eval   (eval),
      .value  (s_q.meas.time_ticks),
      .hi     (s_q.t_hi),
      .lo     (s_q.t_lo),
      .err_hi (err.time_hi),
      .err_lo (err.time_lo)
   );
   weld_bound_chk u_chk_peak (
      .clk    (MCLK),
      .rst_n  (RESET_N),
      .clr    (clr),
      .eval   (eval),
      .value  (s_q.meas.peak_w),
      .hi     (s_q.pk_hi),
      .lo     (s_q.pk_lo),
      .err_hi (err.peak_hi),
      .err_lo (err.peak_lo)
   );
   weld_bound_chk u_chk_energy (
      .clk    (MCLK),
      .rst_n  (RESET_N),
      .clr    (clr),
      .eval   (eval),
      .value  (s_q.meas.energy_ws),
      .hi     (s_q.en_hi),
      .lo     (s_q.en_lo),
      .err_hi (err.en_hi),
      .err_lo (err.en_lo)
   );

   // Frequency scan engine, steps once per 10 ms tick
   weld_scan u_scan (
      .clk    (MCLK),
      .rst_n  (RESET_N),
      .go     (s_q.scan_go),
      .step   (tick),
      .fstart (s_q.fstart),
      .span   (s_q.span),
      .freq   (scan_freq),
      .busy   (scan_busy)
   );

   // Read multiplexer
   always_comb begin
      rd = 32'h0;
      case (AVS_ADDRESS)
         `REG_CTRL:        rd = {28'h0, 1'b0, scan_busy,
                                 s_q.host_run, s_q.out_en};
         `REG_STATUS:      rd = {23'h0, err.en_lo, err.en_hi,
                                 err.peak_lo, err.peak_hi, err.time_lo,
                                 err.time_hi, HOST_ATTACHED, scan_busy,
                                 s_q.out_en};
         `REG_WELD_TIME:   rd = s_q.t_dur;
         `REG_PEAK_TGT:    rd = s_q.pk_tgt;
         `REG_ENERGY_TGT:  rd = s_q.en_tgt;
         `REG_TIME_HI:     rd = s_q.t_hi;
         `REG_TIME_LO:     rd = s_q.t_lo;
         `REG_PEAK_HI:     rd = s_q.pk_hi;
         `REG_PEAK_LO:     rd = s_q.pk_lo;
         `REG_ENERGY_HI:   rd = s_q.en_hi;
         `REG_ENERGY_LO:   rd = s_q.en_lo;
         `REG_FSTART:      rd = {15'h0, s_q.fstart};
         `REG_SPAN:        rd = {16'h0, s_q.span};
         `REG_AMPL:        rd = {22'h0, s_q.ampl};
         `REG_ADDR:        rd = {24'h0, s_q.addr};
         `REG_MEAS_TIME:   rd = s_q.meas.time_ticks;
         `REG_MEAS_PEAK:   rd = s_q.meas.peak_w;
         `REG_MEAS_ENERGY: rd = s_q.meas.energy_ws;
         `REG_OP_POWER:    rd = s_q.op_power;
         `REG_SCAN_FREQ:   rd = {15'h0, scan_freq};
         default:          rd = 32'h0;                       // Unmapped
      endcase
   end

   // Next-state logic: bus, panel, sequencer and measurement
   always_comb begin
      s_d = s_q;
      wv  = 32'h0;
      s_d.scan_go  = 1'b0;
      s_d.memwr    = 1'b0;
      s_d.menu_fs  = 1'b0;
      s_d.btn_prev = PANEL_BUTTON;
      s_d.enc_prev = PANEL_ENC_CW;
      // One wait cycle, then accept; waitrequest drops for one edge
      s_d.wait_q = 1'b1;
      if ((AVS_READ || AVS_WRITE) && s_q.wait_q) begin
         s_d.wait_q = 1'b0;
      end
      // Read data captured early so it stands at the accepting edge
      if (AVS_READ && s_q.wait_q) begin
         s_d.rdata = rd;
      end
      if (acc && AVS_WRITE) begin
         case (AVS_ADDRESS)
            `REG_CTRL: begin
               if (AVS_BYTEENABLE[0]) begin
                  s_d.host_run = AVS_WRITEDATA[`CTRL_RUN];
                  s_d.scan_go  = AVS_WRITEDATA[`CTRL_SCAN];
                  s_d.memwr    = AVS_WRITEDATA[`CTRL_MEMWR];
               end
            end
            `REG_WELD_TIME:  s_d.t_dur  = (s_q.t_dur & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_PEAK_TGT:   s_d.pk_tgt = (s_q.pk_tgt & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_ENERGY_TGT: s_d.en_tgt = (s_q.en_tgt & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_TIME_HI:    s_d.t_hi   = (s_q.t_hi & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_TIME_LO:    s_d.t_lo   = (s_q.t_lo & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_PEAK_HI:    s_d.pk_hi  = (s_q.pk_hi & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_PEAK_LO:    s_d.pk_lo  = (s_q.pk_lo & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_ENERGY_HI:  s_d.en_hi  = (s_q.en_hi & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_ENERGY_LO:  s_d.en_lo  = (s_q.en_lo & ~wmask) |
                                          (AVS_WRITEDATA & wmask);
            `REG_FSTART: begin
               // Accepted in any state, running included
               wv = (32'(s_q.fstart) & ~wmask) | (AVS_WRITEDATA & wmask);
               s_d.fstart = wv[16:0];
            end
            `REG_SPAN: begin
               // Values above 1 kHz are clipped, not wrapped
               wv = (32'(s_q.span) & ~wmask) | (AVS_WRITEDATA & wmask);
               s_d.span = (wv > 32'(`SPAN_MAX_HZ)) ?
                          `SPAN_MAX_HZ : wv[15:0];
            end
            `REG_AMPL: begin
               wv = (32'(s_q.ampl) & ~wmask) | (AVS_WRITEDATA & wmask);
               s_d.ampl = (wv > 32'(`AMPL_MAX)) ?
                          `AMPL_MAX : wv[9:0];
            end
            `REG_ADDR: begin
               if (AVS_BYTEENABLE[0]) begin
                  s_d.addr = AVS_WRITEDATA[7:0];
               end
            end
            default: begin
               // Read-only or unmapped: write ignored
            end
         endcase
      end
      // Panel button rising edge toggles run; ignored while host attached
      if (PANEL_BUTTON && !s_q.btn_prev && !HOST_ATTACHED) begin
         s_d.panel_run = !s_q.panel_run;
      end
      // One clockwise step with memory-write menu commits settings
      if (PANEL_ENC_CW && !s_q.enc_prev && PANEL_MEMWR_SEL) begin
         s_d.memwr   = 1'b1;
         s_d.menu_fs = 1'b1;
      end
      // 10 ms tick counter runs only during a weld
      if (s_q.st == weld_pkg::ST_RUN) begin
         s_d.tick_cnt = tick ? 32'h0 : s_q.tick_cnt + 32'h1;
      end else begin
         s_d.tick_cnt = 32'h0;
      end
      if (MEAS_VALID) begin
         s_d.op_power = MEAS_POWER;
      end
      // Weld sequencer
      case (s_q.st)
         weld_pkg::ST_IDLE: begin
            s_d.out_en = 1'b0;
            if (run_req) begin
               s_d.st         = weld_pkg::ST_RUN;
               s_d.meas       = '0;
               s_d.energy_acc = 32'h0;
               s_d.out_en     = 1'b1;
            end
         end
         weld_pkg::ST_RUN: begin
            if (tick) begin
               s_d.meas.time_ticks = s_q.meas.time_ticks + 32'h1;
            end
            if (MEAS_VALID) begin
               if (MEAS_POWER > s_q.meas.peak_w) begin
                  s_d.meas.peak_w = MEAS_POWER;
               end
               // Watt-cycles; 200e6 of them is one Ws
               if (s_q.energy_acc + MEAS_POWER >= 32'(`CLK_HZ)) begin
                  s_d.energy_acc = s_q.energy_acc + MEAS_POWER -
                                   32'(`CLK_HZ);
                  s_d.meas.energy_ws = s_q.meas.energy_ws + 32'h1;
               end else begin
                  s_d.energy_acc = s_q.energy_acc + MEAS_POWER;
               end
            end
            if (stop_hit || !run_req) begin
               s_d.st     = weld_pkg::ST_CHECK;
               s_d.out_en = 1'b0;
            end
         end
         weld_pkg::ST_CHECK: begin
            // Bounds evaluated here; run requests dropped so welds
            // only restart on a fresh request
            s_d.st        = weld_pkg::ST_IDLE;
            s_d.out_en    = 1'b0;
            s_d.host_run  = 1'b0;
            s_d.panel_run = 1'b0;
         end
         default: begin
            s_d.st     = weld_pkg::ST_IDLE;
            s_d.out_en = 1'b0;
         end
      endcase
      // Bar shows instantaneous amplitude: setpoint while output runs
      s_d.bar = s_d.out_en ? s_q.ampl : 10'h0;
   end

   // State register
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         s_q        <= '0;
         s_q.st     <= weld_pkg::ST_IDLE;
         s_q.fstart <= `FSTART_DEFAULT;
         s_q.span   <= `SPAN_MAX_HZ;
         s_q.addr   <= `ADDR_DEFAULT;
         s_q.wait_q <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops, except WELD_ERROR, an OR of the error flags
   assign AVS_READDATA    = s_q.rdata;
   assign AVS_WAITREQUEST = s_q.wait_q;
   assign US_OUT_EN       = s_q.out_en;
   assign AMPL_SET        = s_q.ampl;
   assign AMPL_BAR        = s_q.bar;
   assign FREQ_OUT        = scan_freq;
   assign NVM_COMMIT      = s_q.memwr;
   assign MENU_TO_FSTART  = s_q.menu_fs;
   assign WELD_ERROR      = |err;
   assign NET_ADDR        = s_q.addr;
endmodule
`default_nettype wire

// File: bench/weld_limit_supervisor_asserts.sv
// Port checker for the weld supervisor: bus timing, pulses, outputs.
// Bound onto every weld_limit_supervisor; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module weld_sup_chk (
   input wire logic        MCLK,
   input wire logic        RESET_N,
   input wire logic [7:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        HOST_ATTACHED,
   input wire logic        PANEL_BUTTON,
   input wire logic        PANEL_ENC_CW,
   input wire logic        PANEL_MEMWR_SEL,
   input wire logic        US_OUT_EN,
   input wire logic [9:0]  AMPL_SET,
   input wire logic [9:0]  AMPL_BAR,
   input wire logic        NVM_COMMIT,
   input wire logic        MENU_TO_FSTART,
   input wire logic        WELD_ERROR,
   input wire logic [7:0]  NET_ADDR
);
   // One clock domain, so clock and reset are named once
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   bus_accept_a: assert property ((AVS_READ || AVS_WRITE) &&
      AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request not accepted next cycle");
   unmapped_zero_a: assert property (AVS_READ && AVS_WAITREQUEST &&
      AVS_ADDRESS == 8'hfc |=> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   addr_reset_a: assert property ($rose(RESET_N) |-> NET_ADDR == 8'h06)
      else $error("address not six after reset");
   ampl_max_a: assert property (AMPL_SET <= 10'h3e8)
      else $error("amplitude above full scale");
   bar_follow_a: assert property ($stable(US_OUT_EN) && $stable(AMPL_SET)
      |-> AMPL_BAR == (US_OUT_EN ? AMPL_SET : 10'h000))
      else $error("bar does not follow amplitude");
   commit_pair_a: assert property (NVM_COMMIT |-> MENU_TO_FSTART ##1
      !NVM_COMMIT)
      else $error("commit pulse malformed");
   commit_cause_a: assert property ($rose(PANEL_ENC_CW) &&
      PANEL_MEMWR_SEL |-> ##[1:2] NVM_COMMIT)
      else $error("encoder step did not commit");
   err_clear_a: assert property ($rose(US_OUT_EN) |-> !WELD_ERROR)
      else $error("error kept at weld start");
   button_on_a: assert property ($rose(PANEL_BUTTON) && !HOST_ATTACHED &&
      !US_OUT_EN |-> ##[1:2] US_OUT_EN)
      else $error("button did not start output");
   host_wins_a: assert property ($rose(PANEL_BUTTON) && HOST_ATTACHED &&
      !US_OUT_EN |-> ##1 !US_OUT_EN ##1 !US_OUT_EN)
      else $error("panel button acted under host");
endmodule
bind weld_limit_supervisor weld_sup_chk i_chk (.*);
`default_nettype wire

// File: bench/weld_panel_model.sv
// Operator panel and load sensor: power samples, button, encoder.
// Driven by the bench through request inputs on its clock.
`timescale 1ns/1ps
`default_nettype none
module weld_panel_model (
   input wire logic        clk,
   input wire logic [31:0] level,
   input wire logic        press,
   input wire logic        turn,
   output logic [31:0]     power,
   output logic            valid,
   output logic            button,
   output logic            enc_cw
);
   // Sensor samples every cycle; a hand lags its request by one cycle
   always_ff @(posedge clk) begin
      power  <= level;
      valid  <= 1'b1;
      button <= press;
      enc_cw <= turn;
   end
endmodule
`default_nettype wire

// File: bench/tb_weld_limit_supervisor.sv
// Self-checking bench for the weld supervisor over Avalon-MM and panel.
// Needs the design, the panel model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_weld_limit_supervisor;
   logic        MCLK = 1'b0, RESET_N = 1'b0; // Clock and reset
   logic [7:0]  adr = 8'h00, naddr;        // Bus address, net address
   logic        rd = 1'b0, wr = 1'b0;      // Bus strobes
   logic [31:0] wd = 32'h0, rdat, power, v, lvl = 32'h0;
   logic [31:0] lfsr = 32'h274f;           // Random source
   logic        host = 1'b0, press = 1'b0, turn = 1'b0, msel = 1'b0;
   logic        valid, btn, enc, wreq, out_en, commit, menu, werr;
   logic [9:0]  aset, abar, amp, amp_e;
   logic [16:0] freq;
   int          err_total = 0, checks_done = 0, n;
   always #2.5 MCLK = ~MCLK;
   weld_panel_model i_panel (.clk(MCLK), .level(lvl), .press(press),
      .turn(turn), .power(power), .valid(valid), .button(btn),
      .enc_cw(enc));
   // Byte lanes tied: full words only
   weld_limit_supervisor i_dut (.MCLK(MCLK), .RESET_N(RESET_N),
      .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .HOST_ATTACHED(host), .PANEL_BUTTON(btn),
      .PANEL_ENC_CW(enc), .PANEL_MEMWR_SEL(msel), .MEAS_POWER(power),
      .MEAS_VALID(valid), .US_OUT_EN(out_en), .AMPL_SET(aset),
      .AMPL_BAR(abar), .FREQ_OUT(freq), .NVM_COMMIT(commit),
      .MENU_TO_FSTART(menu), .WELD_ERROR(werr), .NET_ADDR(naddr));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // A spent wait bound is a mismatch and ends the run
   task automatic tmo(int lim);
      if (n >= lim) begin
         err_total++;
         finish_test();
      end
   endtask
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge MCLK);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      v = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      tmo(50);
   endtask
   task automatic rdc(logic [7:0] a, logic [31:0] e, string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, v);
   endtask
   task automatic wait_off(int lim);
      n = 0;
      while (out_en !== 1'b0 && n < lim) begin
         @(posedge MCLK);
         n++;
      end
      tmo(lim);
   endtask
   // Press held a few cycles, then output settles
   task automatic push();
      press <= 1'b1;
      repeat (3) @(posedge MCLK);
      press <= 1'b0;
      repeat (4) @(posedge MCLK);
   endtask
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Reference bound model, zero meaning no bound, as STATUS[8:3]
   function automatic logic [5:0] flags(int t, p, e, th, tl, ph, pl,
      eh, el);
      return {el != 0 && e < el, eh != 0 && e > eh, pl != 0 && p < pl,
              ph != 0 && p > ph, tl != 0 && t < tl, th != 0 && t > th};
   endfunction
   initial begin
      repeat (3) @(posedge MCLK);
      RESET_N <= 1'b1;
      @(posedge MCLK);
      chk("net addr", 8'h06, naddr);
      chk("freq rst", 21000, freq);
      rdc(8'h38, 6, "addr reg");
      bus(1'b1, 8'h38, 8'h2a);
      rdc(8'h38, 8'h2a, "addr set");
      rdc(8'hfc, 0, "unmapped");
      bus(1'b1, 8'h30, 2000);
      rdc(8'h30, 1000, "span clip");
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         amp = (i == 0) ? 10'h3ff : lfsr[9:0];
         amp_e = (amp > 10'h3e8) ? 10'h3e8 : amp;
         bus(1'b1, 8'h34, {22'h0, amp});
         repeat (2) @(posedge MCLK);
         chk("ampl", amp_e, aset);
      end
      // Peak weld under host control, time and peak bounds broken
      host <= 1'b1;
      bus(1'b1, 8'h0c, 100);
      bus(1'b1, 8'h1c, 99);
      bus(1'b1, 8'h18, 1);
      lvl <= 50;
      bus(1'b1, 8'h00, 1);
      repeat (5) @(posedge MCLK);
      chk("running", 1, out_en);
      lvl <= 100;
      wait_off(8);
      repeat (3) @(posedge MCLK);
      rdc(8'h40, 100, "peak");
      bus(1'b0, 8'h04, 0);
      chk("flags1", flags(0, 100, 0, 0, 1, 99, 0, 0, 0), v[8:3]);
      // Energy weld, energy over and peak under their bounds
      bus(1'b1, 8'h0c, 0);
      bus(1'b1, 8'h1c, 0);
      bus(1'b1, 8'h18, 0);
      bus(1'b1, 8'h20, 32'h02000000);
      bus(1'b1, 8'h10, 2);
      bus(1'b1, 8'h24, 1);
      lvl <= 32'h01000000;
      bus(1'b1, 8'h00, 1);
      repeat (2) @(posedge MCLK);
      chk("err clear", 0, werr);
      wait_off(40);
      repeat (3) @(posedge MCLK);
      rdc(8'h44, 2, "energy");
      bus(1'b0, 8'h04, 0);
      chk("flags2", flags(0, 32'h01000000, 2, 0, 0, 0, 32'h02000000, 1,
         0), v[8:3]);
      chk("weld err", 1, werr);
      rdc(8'h48, 32'h01000000, "op power");
      // Panel control: ignored under host, toggles once detached
      bus(1'b1, 8'h10, 0);
      bus(1'b1, 8'h24, 0);
      bus(1'b1, 8'h20, 0);
      push();
      chk("host wins", 0, out_en);
      host <= 1'b0;
      push();
      chk("panel on", 1, out_en);
      bus(1'b1, 8'h2c, 20500);
      repeat (2) @(posedge MCLK);
      chk("fstart run", 20500, freq);
      chk("bar", amp_e, abar);
      push();
      chk("panel off", 0, out_en);
      // One clockwise step on the memory-write menu
      msel <= 1'b1;
      turn <= 1'b1;
      @(posedge MCLK);
      turn <= 1'b0;
      n = 0;
      while (commit !== 1'b1 && n < 6) begin
         @(posedge MCLK);
         n++;
      end
      tmo(6);
      chk("menu", 1, menu);
      // Scan starts at the start frequency and reports busy
      bus(1'b1, 8'h00, 32'h4);
      rdc(8'h4c, 20500, "scan start");
      rdc(8'h04, 32'h2, "scan busy");
      chk("scan freq", 20500, freq);
      finish_test();
   end
endmodule
`default_nettype wire
